/* hdl/dpa_port.sv */
// Debug port access engine with data trace range filter
`timescale 1ns/1ps
`default_nettype none
`include "dpa_defines.svh"

// How it works
// - 34-bit transfer register: 32 data bits above two status bits.
// - Read data right-justified by size, unused upper bytes zero.
// - Transfer data and access write data are one shared store.
// - Status bits read-only to the tool, set only by access logic.
// - Read status: 00 pending, 01 done, 10 error, never 11.
// - Write status: 00 done, 01 pending, 10 error plus error message.
// - Two 48-bit ranges: end 47:25, start 24:2, trace type 1:0.
// - Type low bit enables read trace, high bit write trace.
// - Start below end inclusive, equal one word, start above end none.
// - Matching uses address only, special registers traced alike.
// - Single write: request code 18, device answers ready code 16.
// - Single read: request code 18, device answers data code 19.
// - Block write: code 16 then tool code 19 per later datum.
// - Block read: one code 19 message per datum until done.
// - Tool register write by code 18, answered by code 16.
// - Tool register read by code 17, answered by code 19.
// - Short download fills register MSBs, missing bits cleared.
// - Block steps by size from start; count zero is one access.

module dpa_port (
	input wire logic clock,                  // System clock
	input wire logic arst_n,                 // Tool reset, async, low
	input wire logic link_clock,             // Tool message clock
	input wire logic link_msg_valid,         // Message strobe, link side
	input wire dpa_pkg::dpa_msg_type link_msg, // Decoded tool message
	output logic link_busy,                  // Message held, link side
	output dpa_pkg::dpa_mem_req_type mem_out, // Memory access request
	input wire logic mem_ack,                // Memory access done
	input wire logic mem_err,                // Memory access failed
	input wire logic [31:0] mem_rdata,       // Memory read data
	output logic out_valid,                  // Outgoing message valid
	output dpa_pkg::dpa_out_type out_msg,    // Outgoing message
	input wire logic out_ready,              // Outgoing message taken
	input wire logic ls_valid,               // Core load/store strobe
	input wire logic ls_write,               // Store when high
	input wire logic [24:0] ls_addr,         // Load/store address
	output logic trace_read,                 // Read trace pulse
	output logic trace_write                 // Write trace pulse
);
	import dpa_pkg::*;

	// -------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------
	function automatic logic [79:0] dpa_align(input logic [79:0] p,
		input logic [6:0] n, input logic [6:0] w);
		logic [79:0] keep;
		logic [79:0] mask;
		keep = p & ~(~80'h0 << n);
		mask = ~(~80'h0 << w);
		if (n >= w) begin
			dpa_align = p & mask;
		end else begin
			dpa_align = (keep << (w - n)) & mask;
		end
	endfunction

	function automatic logic [31:0] dpa_justify(input logic [31:0] d,
		input logic [1:0] sz);
		case (sz)
			`DPA_SZ_BYTE: dpa_justify = {24'h0, d[7:0]};
			`DPA_SZ_HALF: dpa_justify = {16'h0, d[15:0]};
			default: dpa_justify = d;
		endcase
	endfunction

	function automatic logic [24:0] dpa_step(input logic [1:0] sz);
		case (sz)
			`DPA_SZ_BYTE: dpa_step = 25'h1;
			`DPA_SZ_HALF: dpa_step = 25'h2;
			default: dpa_step = 25'h4;
		endcase
	endfunction

	// -------------------------------------------------------------
	// Link domain: hold message, toggle request
	// -------------------------------------------------------------
	dpa_msg_type hold_q;
	logic req_tgl_q;
	logic ack_s1_q;
	logic ack_s2_q;
	logic ack_tgl_q;

	assign link_busy = req_tgl_q ^ ack_s2_q;

	always_ff @(posedge link_clock or negedge arst_n) begin
		if (!arst_n) begin
			hold_q <= '0;
			req_tgl_q <= 1'b0;
		end else if (link_msg_valid && !link_busy) begin
			hold_q <= link_msg;
			req_tgl_q <= ~req_tgl_q;
		end
	end

	always_ff @(posedge link_clock or negedge arst_n) begin
		if (!arst_n) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else begin
			ack_s1_q <= ack_tgl_q;
			ack_s2_q <= ack_s1_q;
		end
	end

	// -------------------------------------------------------------
	// System domain: request synchroniser
	// -------------------------------------------------------------
	logic req_s1_q;
	logic req_s2_q;
	logic req_s3_q;
	logic new_msg;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
			ack_tgl_q <= 1'b0;
		end else begin
			req_s1_q <= req_tgl_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
			ack_tgl_q <= req_s2_q;
		end
	end

	assign new_msg = req_s2_q ^ req_s3_q;

	// -------------------------------------------------------------
	// Message decode
	// -------------------------------------------------------------
	dpa_state_type state_q;
	logic take;
	logic is_down;
	logic [79:0] al_access;
	logic [79:0] al_xfer;
	logic [79:0] al_range;

	assign take = new_msg && (state_q == DPA_ST_IDLE);
	assign is_down = take && (hold_q.tcode == `DPA_TC_DOWNLOAD_REQ);
	assign al_access = dpa_align(hold_q.payload, hold_q.nbits, `DPA_W_ACCESS);
	assign al_xfer = dpa_align(hold_q.payload, hold_q.nbits, `DPA_W_XFER);
	assign al_range = dpa_align(hold_q.payload, hold_q.nbits, `DPA_W_RANGE);

	// -------------------------------------------------------------
	// Tool-mapped registers
	// -------------------------------------------------------------
	logic [79:0] ac_q;
	logic [47:0] range1_q;
	logic [47:0] range2_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ac_q <= `DPA_AC_RST;
			range1_q <= `DPA_RANGE_RST;
			range2_q <= `DPA_RANGE_RST;
		end else if (is_down) begin
			case (hold_q.opcode)
				`DPA_OP_ACCESS: ac_q <= al_access;
				`DPA_OP_RANGE1: range1_q <= al_range[47:0];
				`DPA_OP_RANGE2: range2_q <= al_range[47:0];
				default: ac_q <= ac_q;
			endcase
		end
	end

	// -------------------------------------------------------------
	// Access engine
	// -------------------------------------------------------------
	logic [31:0] xfer_data_q;
	logic [1:0] status_q;
	logic active_q;
	logic we_q;
	logic [24:0] addr_q;
	logic [15:0] cnt_q;
	logic [1:0] size_q;
	dpa_out_type out_q;
	logic [79:0] reg_rd;
	logic [31:0] rd_just;
	logic more;

	assign rd_just = dpa_justify(mem_rdata, size_q);
	assign more = active_q && (cnt_q != 16'h0);

	always_comb begin
		case (hold_q.opcode)
			`DPA_OP_ACCESS: reg_rd = {active_q, ac_q[78:51], xfer_data_q,
				ac_q[18:0]};
			`DPA_OP_XFER: reg_rd = {46'h0, xfer_data_q, status_q};
			`DPA_OP_RANGE1: reg_rd = {32'h0, range1_q};
			`DPA_OP_RANGE2: reg_rd = {32'h0, range2_q};
			default: reg_rd = 80'h0;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= DPA_ST_IDLE;
			xfer_data_q <= 32'h0;
			status_q <= 2'h0;
			active_q <= 1'b0;
			we_q <= 1'b0;
			addr_q <= 25'h0;
			cnt_q <= 16'h0;
			size_q <= `DPA_SZ_WORD;
			out_q <= '0;
		end else begin
			case (state_q)
				DPA_ST_IDLE: begin
					if (take && hold_q.tcode == `DPA_TC_UPLOAD_REQ) begin
						out_q <= '{tcode: `DPA_TC_INFO, payload: reg_rd};
						state_q <= DPA_ST_INFO;
					end else if (is_down) begin
						out_q <= '{tcode: `DPA_TC_READY, payload: 80'h0};
						state_q <= DPA_ST_READY;
						if (hold_q.opcode == `DPA_OP_XFER) begin
							xfer_data_q <= al_xfer[`DPA_XF_DATA_HI:`DPA_XF_DATA_LO];
						end
						if (hold_q.opcode == `DPA_OP_ACCESS) begin
							xfer_data_q <= al_access[`DPA_AC_WD_HI:`DPA_AC_WD_LO];
							if (al_access[`DPA_AC_SC]) begin
								active_q <= 1'b1;
								we_q <= al_access[`DPA_AC_RW];
								addr_q <= al_access[`DPA_AC_ADDR_HI:`DPA_AC_ADDR_LO];
								cnt_q <= al_access[`DPA_AC_CNT_HI:0];
								size_q <= (al_access[`DPA_AC_SZ_HI:`DPA_AC_SZ_LO] == 2'h3) ?
									`DPA_SZ_WORD : al_access[`DPA_AC_SZ_HI:`DPA_AC_SZ_LO];
								status_q <= al_access[`DPA_AC_RW] ? 2'h1 : 2'h0;
								state_q <= DPA_ST_MEM;
							end
						end
					end
				end
				DPA_ST_MEM: begin
					if (mem_ack) begin
						if (mem_err) begin
							status_q <= 2'h2;
							active_q <= 1'b0;
							if (we_q) begin
								out_q <= '{tcode: `DPA_TC_ERROR,
									payload: {75'h0, `DPA_ERR_CODE_WRITE}};
								state_q <= DPA_ST_ERROR;
							end else begin
								out_q <= '{tcode: `DPA_TC_INFO,
									payload: {46'h0, xfer_data_q, 2'h2}};
								state_q <= DPA_ST_INFO;
							end
						end else if (we_q) begin
							status_q <= 2'h0;
							out_q <= '{tcode: `DPA_TC_READY, payload: 80'h0};
							state_q <= DPA_ST_READY;
						end else begin
							xfer_data_q <= rd_just;
							status_q <= 2'h1;
							out_q <= '{tcode: `DPA_TC_INFO,
								payload: {46'h0, rd_just, 2'h1}};
							state_q <= DPA_ST_INFO;
						end
					end
				end
				DPA_ST_INFO: begin
					if (out_ready) begin
						if (more) begin
							cnt_q <= cnt_q - 16'h1;
							addr_q <= addr_q + dpa_step(size_q);
							status_q <= 2'h0;
							state_q <= DPA_ST_MEM;
						end else begin
							active_q <= 1'b0;
							state_q <= DPA_ST_IDLE;
						end
					end
				end
				DPA_ST_READY: begin
					if (out_ready) begin
						if (more) begin
							cnt_q <= cnt_q - 16'h1;
							addr_q <= addr_q + dpa_step(size_q);
							state_q <= DPA_ST_WDATA;
						end else begin
							active_q <= 1'b0;
							state_q <= DPA_ST_IDLE;
						end
					end
				end
				DPA_ST_WDATA: begin
					if (new_msg && hold_q.tcode == `DPA_TC_INFO) begin
						xfer_data_q <= dpa_justify(hold_q.payload[31:0], size_q);
						status_q <= 2'h1;
						state_q <= DPA_ST_MEM;
					end
				end
				DPA_ST_ERROR: begin
					if (out_ready) begin
						out_q <= '{tcode: `DPA_TC_READY, payload: 80'h0};
						state_q <= DPA_ST_READY;
					end
				end
				default: state_q <= DPA_ST_IDLE;
			endcase
		end
	end

	assign out_valid = (state_q == DPA_ST_INFO) || (state_q == DPA_ST_READY) ||
		(state_q == DPA_ST_ERROR);
	assign out_msg = out_q;
	assign mem_out = '{req: (state_q == DPA_ST_MEM), we: we_q, addr: addr_q,
		size: size_q, prv: ac_q[`DPA_AC_PRV_HI:`DPA_AC_PRV_LO],
		map: ac_q[`DPA_AC_MAP], wdata: dpa_justify(xfer_data_q, size_q)};

	// -------------------------------------------------------------
	// Data trace filter
	// -------------------------------------------------------------
	logic r1_rd;
	logic r1_wr;
	logic r2_rd;
	logic r2_wr;
	logic trace_read_q;
	logic trace_write_q;

	dpa_range_match u_range1 (
		.range(range1_q),
		.addr(ls_addr),
		.read_hit(r1_rd),
		.write_hit(r1_wr)
	);

	dpa_range_match u_range2 (
		.range(range2_q),
		.addr(ls_addr),
		.read_hit(r2_rd),
		.write_hit(r2_wr)
	);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			trace_read_q <= 1'b0;
			trace_write_q <= 1'b0;
		end else begin
			trace_read_q <= ls_valid && !ls_write && (r1_rd || r2_rd);
			trace_write_q <= ls_valid && ls_write && (r1_wr || r2_wr);
		end
	end

	assign trace_read = trace_read_q;
	assign trace_write = trace_write_q;

	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence s_write_fail;
		state_q == DPA_ST_MEM && mem_ack && mem_err && we_q;
	endsequence

	sequence s_error_sent;
		out_valid && out_msg.tcode == `DPA_TC_ERROR && out_ready;
	endsequence

	property p_status_legal;
		status_q != 2'h3;
	endproperty
	a_status_legal: assert property (p_status_legal)
		else $error("status shows both flags set");

	property p_write_done_ready;
		state_q == DPA_ST_MEM && mem_ack && !mem_err && we_q |=>
			out_valid && out_msg.tcode == `DPA_TC_READY && status_q == 2'h0;
	endproperty
	a_write_done_ready: assert property (p_write_done_ready)
		else $error("good write not answered by ready");

	property p_read_data;
		state_q == DPA_ST_MEM && mem_ack && !mem_err && !we_q |=>
			out_msg.tcode == `DPA_TC_INFO && status_q == 2'h1 &&
			out_msg.payload[33:2] == $past(rd_just);
	endproperty
	a_read_data: assert property (p_read_data)
		else $error("read data message wrong");

	property p_byte_justified;
		status_q == 2'h1 && !we_q && size_q == `DPA_SZ_BYTE &&
			state_q == DPA_ST_INFO |-> xfer_data_q[31:8] == 24'h0;
	endproperty
	a_byte_justified: assert property (p_byte_justified)
		else $error("byte read not right justified");

	property p_write_error;
		s_write_fail |=> out_valid && out_msg.tcode == `DPA_TC_ERROR &&
			out_msg.payload[4:0] == `DPA_ERR_CODE_WRITE && status_q == 2'h2;
	endproperty
	a_write_error: assert property (p_write_error)
		else $error("write error message wrong");

	property p_error_ready;
		s_error_sent |=>
			out_valid && out_msg.tcode == `DPA_TC_READY && status_q == 2'h2;
	endproperty
	a_error_ready: assert property (p_error_ready)
		else $error("ready missing after write error message");

	property p_status_source;
		$changed(status_q) |-> $past(state_q == DPA_ST_MEM ||
			state_q == DPA_ST_WDATA || state_q == DPA_ST_INFO || is_down);
	endproperty
	a_status_source: assert property (p_status_source)
		else $error("status changed outside access logic");

	property p_block_step;
		state_q == DPA_ST_INFO && out_ready && more |=>
			state_q == DPA_ST_MEM && cnt_q == $past(cnt_q) - 16'h1 &&
			addr_q == $past(addr_q) + $past(dpa_step(size_q));
	endproperty
	a_block_step: assert property (p_block_step)
		else $error("block step wrong");

	property p_upload_reply;
		take && hold_q.tcode == `DPA_TC_UPLOAD_REQ |=>
			out_valid && out_msg.tcode == `DPA_TC_INFO;
	endproperty
	a_upload_reply: assert property (p_upload_reply)
		else $error("upload request not answered");

	property p_trace_off;
		$past(range1_q[1:0] == 2'h0 && range2_q[1:0] == 2'h0) |->
			!trace_read && !trace_write;
	endproperty
	a_trace_off: assert property (p_trace_off)
		else $error("trace emitted with both ranges disabled");

endmodule // dpa_port
`default_nettype wire

/* hdl/dpa_defines.svh */
// Constants for the debug port access block: codes, opcodes, field positions
`ifndef DPA_DEFINES_SVH
`define DPA_DEFINES_SVH

// -----------------------------------------------------------------
// Message codes
// -----------------------------------------------------------------
`define DPA_TC_READY 6'h10
`define DPA_TC_UPLOAD_REQ 6'h11
`define DPA_TC_DOWNLOAD_REQ 6'h12
`define DPA_TC_INFO 6'h13
`define DPA_TC_ERROR 6'h08
`define DPA_ERR_CODE_WRITE 5'h01

// -----------------------------------------------------------------
// Tool-mapped register opcodes and widths
// -----------------------------------------------------------------
`define DPA_OP_ACCESS 6'h07
`define DPA_OP_XFER 6'h08
`define DPA_OP_RANGE1 6'h0a
`define DPA_OP_RANGE2 6'h0b
`define DPA_W_ACCESS 7'd80
`define DPA_W_XFER 7'd34
`define DPA_W_RANGE 7'd48

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define DPA_AC_SC 79
`define DPA_AC_ADDR_HI 78
`define DPA_AC_ADDR_LO 54
`define DPA_AC_RW 53
`define DPA_AC_SZ_HI 52
`define DPA_AC_SZ_LO 51
`define DPA_AC_WD_HI 50
`define DPA_AC_WD_LO 19
`define DPA_AC_PRV_HI 18
`define DPA_AC_PRV_LO 17
`define DPA_AC_MAP 16
`define DPA_AC_CNT_HI 15
`define DPA_XF_DATA_HI 33
`define DPA_XF_DATA_LO 2
`define DPA_ST_ERR 1
`define DPA_ST_VALID 0
`define DPA_RG_END_HI 47
`define DPA_RG_END_LO 25
`define DPA_RG_START_HI 24
`define DPA_RG_START_LO 2
`define DPA_RG_WRITE_EN 1
`define DPA_RG_READ_EN 0

// -----------------------------------------------------------------
// Reset values and size codes
// -----------------------------------------------------------------
`define DPA_RANGE_RST 48'h0
`define DPA_AC_RST 80'h0
`define DPA_SZ_WORD 2'h0
`define DPA_SZ_HALF 2'h1
`define DPA_SZ_BYTE 2'h2

`endif

/* hdl/dpa_pkg.sv */
// Types shared by the debug port access block
`default_nettype none
package dpa_pkg;

	typedef enum logic [5:0] {
		DPA_ST_IDLE = 6'h01,
		DPA_ST_MEM = 6'h02,
		DPA_ST_INFO = 6'h04,
		DPA_ST_READY = 6'h08,
		DPA_ST_WDATA = 6'h10,
		DPA_ST_ERROR = 6'h20
	} dpa_state_type;

	typedef struct packed {
		logic [5:0] tcode;
		logic [5:0] opcode;
		logic [6:0] nbits;
		logic [79:0] payload;
	} dpa_msg_type;

	typedef struct packed {
		logic [5:0] tcode;
		logic [79:0] payload;
	} dpa_out_type;

	typedef struct packed {
		logic req;
		logic we;
		logic [24:0] addr;
		logic [1:0] size;
		logic [1:0] prv;
		logic map;
		logic [31:0] wdata;
	} dpa_mem_req_type;

endpackage
`default_nettype wire

/* hdl/dpa_range_match.sv */
// Address range matcher for one trace-range register
`timescale 1ns/1ps
`default_nettype none
`include "dpa_defines.svh"

module dpa_range_match (
	input wire logic [47:0] range,  // Trace-range register contents
	input wire logic [24:0] addr,   // Load/store address
	output logic read_hit,          // Address hits with read trace on
	output logic write_hit          // Address hits with write trace on
);
	logic [22:0] start_w;
	logic [22:0] end_w;
	logic in_range;

	assign start_w = range[`DPA_RG_START_HI:`DPA_RG_START_LO];
	assign end_w = range[`DPA_RG_END_HI:`DPA_RG_END_LO];
	// Start above end matches nothing; equal covers one word
	assign in_range = (start_w <= end_w) && (addr[24:2] >= start_w) &&
		(addr[24:2] <= end_w);
	assign read_hit = in_range && range[`DPA_RG_READ_EN];
	assign write_hit = in_range && range[`DPA_RG_WRITE_EN];
endmodule // dpa_range_match
`default_nettype wire

/* test/dpa_tool_model.sv */
// Tool-side model of the auxiliary message port
`timescale 1ns/1ps
`default_nettype none

module dpa_tool_model
	import dpa_pkg::*;
(
	input wire logic clock,                   // System clock
	input wire logic link_clock,              // Tool message clock
	input wire logic link_busy,               // Device holding a message
	output logic link_msg_valid,              // Message strobe
	output dpa_pkg::dpa_msg_type link_msg,    // Message to the device
	input wire logic out_valid,               // Device message valid
	input wire dpa_pkg::dpa_out_type out_msg, // Device message
	output logic out_ready                    // Device message taken
);
	initial begin
		link_msg_valid = 1'b0;
		link_msg = '0;
		out_ready = 1'b0;
	end

	// Wait until the port is free, then offer one message for one link clock
	task automatic send(input logic [5:0] tc, input logic [5:0] op,
		input logic [6:0] nb, input logic [79:0] pl);
		@(negedge link_clock);
		while (link_busy !== 1'b0) @(negedge link_clock);
		link_msg_valid = 1'b1;
		link_msg = '{tcode: tc, opcode: op, nbits: nb, payload: pl};
		@(negedge link_clock);
		link_msg_valid = 1'b0;
		// Released lines no longer show the last message
		link_msg = ~link_msg;
	endtask

	// Take one device message after a stall of some cycles
	task automatic recv(input int stall, output dpa_out_type m);
		int n;
		n = 0;
		@(negedge clock);
		while (out_valid !== 1'b1 && n < 4000) begin
			@(negedge clock);
			n++;
		end
		if (n >= 4000) begin
			// No reply: hand back unknowns so the caller's compare fails
			m = 'x;
		end else begin
			repeat (stall) @(negedge clock);
			out_ready = 1'b1;
			m = out_msg;
			@(negedge clock);
			out_ready = 1'b0;
		end
	endtask
endmodule // dpa_tool_model

`default_nettype wire

/* test/test_debug_port_access_and_data_trace_filter.sv */
// Self-checking bench for the debug port access block
`timescale 1ns/1ps
`default_nettype none
`include "dpa_defines.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end

module test_debug_port_access_and_data_trace_filter;
	import dpa_pkg::*;
	logic clock = 1'b0;
	logic link_clock = 1'b0;
	logic arst_n = 1'b0;
	logic link_msg_valid, link_busy, out_valid, out_ready;
	logic trace_read, trace_write;
	dpa_msg_type link_msg;
	dpa_out_type out_msg, m;
	dpa_mem_req_type mem_out;
	dpa_mem_req_type mq[$];
	logic mem_ack = 1'b0;
	logic mem_err = 1'b0;
	logic err_on = 1'b0;
	logic [31:0] mem_rdata = 32'h0;
	logic ls_valid = 1'b0;
	logic ls_write = 1'b0;
	logic [24:0] ls_addr = 25'h0;
	logic [1:0] szs[3] = '{`DPA_SZ_WORD, `DPA_SZ_HALF, `DPA_SZ_BYTE};
	logic [31:0] msk[3] = '{32'hffffffff, 32'h0000ffff, 32'h000000ff};
	int bad_count = 0;
	int num_checks = 0;

	always #12.5 clock = ~clock;
	initial begin
		#3.3;
		forever #24 link_clock = ~link_clock;
	end

	dpa_port dut_u (.clock(clock), .arst_n(arst_n), .link_clock(link_clock),
		.link_msg_valid(link_msg_valid), .link_msg(link_msg),
		.link_busy(link_busy), .mem_out(mem_out), .mem_ack(mem_ack),
		.mem_err(mem_err), .mem_rdata(mem_rdata), .out_valid(out_valid),
		.out_msg(out_msg), .out_ready(out_ready), .ls_valid(ls_valid),
		.ls_write(ls_write), .ls_addr(ls_addr), .trace_read(trace_read),
		.trace_write(trace_write));

	dpa_tool_model tool_u (.clock(clock), .link_clock(link_clock),
		.link_busy(link_busy), .link_msg_valid(link_msg_valid),
		.link_msg(link_msg), .out_valid(out_valid), .out_msg(out_msg),
		.out_ready(out_ready));

	function automatic logic [31:0] rd_of(input logic [24:0] a);
		return {a[7:0] ^ 8'h96, 8'h5a, 8'hc3, a[7:0]};
	endfunction

	function automatic logic [47:0] rg(input logic [24:0] s, e,
		input logic [1:0] t);
		return {e[24:2], s[24:2], t};
	endfunction

	// Memory answers each request at the next falling edge
	always @(negedge clock) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_out.req === 1'b1 && !mem_ack) begin
			mem_ack <= 1'b1;
			mem_err <= err_on;
			mem_rdata <= rd_of(mem_out.addr);
			mq.push_back(mem_out);
		end
	end

	task automatic conclude();
		$display("checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic access(input logic rw, input logic [1:0] sz,
		input logic [24:0] a, input logic [31:0] wd, input logic [15:0] cnt);
		tool_u.send(`DPA_TC_DOWNLOAD_REQ, `DPA_OP_ACCESS, `DPA_W_ACCESS,
			{1'b1, a, rw, sz, wd, 2'b10, 1'b1, cnt});
	endtask

	task automatic upload(input logic [5:0] op);
		tool_u.send(`DPA_TC_UPLOAD_REQ, op, 7'd0, 80'h0);
		tool_u.recv(0, m);
		`CHK(m.tcode, `DPA_TC_INFO)
	endtask

	task automatic prog(input logic [5:0] op, input logic [47:0] v);
		tool_u.send(`DPA_TC_DOWNLOAD_REQ, op, `DPA_W_RANGE, {32'h0, v});
		tool_u.recv(1, m);
		`CHK(m.tcode, `DPA_TC_READY)
		upload(op);
		`CHK(m.payload[47:0], v)
	endtask

	task automatic ls(input logic [24:0] a, input logic w, input logic er,
		input logic ew);
		@(negedge clock);
		ls_valid = 1'b1;
		ls_write = w;
		ls_addr = a;
		@(negedge clock);
		ls_valid = 1'b0;
		ls_addr = ~a;
		`CHK({trace_read, trace_write}, {er, ew})
	endtask

	initial begin
		#1_000_000;
		bad_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		conclude();
	end

	initial begin
		logic [24:0] a;
		repeat (8) @(negedge clock);
		arst_n = 1'b1;
		upload(`DPA_OP_XFER);
		`CHK(m.payload[33:0], 34'h0)
		upload(`DPA_OP_RANGE1);
		`CHK(m.payload[47:0], `DPA_RANGE_RST)
		// ---------------------------------------------------------
		// Single accesses
		// ---------------------------------------------------------
		for (int i = 0; i < 3; i++) begin
			a = 25'h1_0040 + 25'(2 * i);
			mq.delete();
			access(1'b0, szs[i], a, 32'h0, 16'h0);
			tool_u.recv(i, m);
			`CHK(m.tcode, `DPA_TC_INFO)
			`CHK(m.payload[33:0], {rd_of(a) & msk[i], 2'b01})
			`CHK({mq[0].we, mq[0].addr, mq[0].size}, {1'b0, a, szs[i]})
		end
		err_on = 1'b1;
		access(1'b0, `DPA_SZ_WORD, 25'h1_0080, 32'h0, 16'h0);
		tool_u.recv(0, m);
		`CHK({m.tcode, m.payload[1:0]}, {`DPA_TC_INFO, 2'b10})
		access(1'b1, `DPA_SZ_WORD, 25'h1_0084, 32'h1234_5678, 16'h0);
		tool_u.recv(0, m);
		`CHK({m.tcode, m.payload[4:0]}, {`DPA_TC_ERROR, `DPA_ERR_CODE_WRITE})
		tool_u.recv(0, m);
		`CHK(m.tcode, `DPA_TC_READY)
		upload(`DPA_OP_XFER);
		`CHK(m.payload[1:0], 2'b10)
		err_on = 1'b0;
		mq.delete();
		access(1'b1, `DPA_SZ_WORD, 25'h1_0100, 32'hcafe_0123, 16'h0);
		tool_u.recv(3, m);
		`CHK(m.tcode, `DPA_TC_READY)
		`CHK({mq[0].we, mq[0].addr}, {1'b1, 25'h1_0100})
		`CHK(mq[0].wdata, 32'hcafe_0123)
		`CHK({mq[0].prv, mq[0].map}, 3'b101)
		upload(`DPA_OP_XFER);
		`CHK(m.payload[33:0], {32'hcafe_0123, 2'b00})
		tool_u.send(`DPA_TC_DOWNLOAD_REQ, `DPA_OP_XFER, `DPA_W_XFER,
			{46'h0, 32'h5555_aaaa, 2'b11});
		tool_u.recv(0, m);
		`CHK(m.tcode, `DPA_TC_READY)
		upload(`DPA_OP_XFER);
		`CHK(m.payload[33:0], {32'h5555_aaaa, 2'b00})
		upload(`DPA_OP_ACCESS);
		`CHK(m.payload[50:19], 32'h5555_aaaa)
		// ---------------------------------------------------------
		// Block accesses
		// ---------------------------------------------------------
		mq.delete();
		access(1'b0, `DPA_SZ_HALF, 25'h1_0200, 32'h0, 16'h1);
		for (int i = 0; i < 2; i++) begin
			a = 25'h1_0200 + 25'(2 * i);
			tool_u.recv(2, m);
			`CHK(m.payload[33:0], {rd_of(a) & 32'hffff, 2'b01})
			`CHK(mq[i].addr, a)
		end
		mq.delete();
		access(1'b1, `DPA_SZ_BYTE, 25'h1_0300, 32'h0000_00a1, 16'h1);
		tool_u.recv(0, m);
		`CHK(m.tcode, `DPA_TC_READY)
		tool_u.send(`DPA_TC_INFO, 6'h0, 7'd32, {48'h0, 32'h0000_00b2});
		tool_u.recv(0, m);
		`CHK(m.tcode, `DPA_TC_READY)
		`CHK({mq[0].addr, mq[1].addr}, {25'h1_0300, 25'h1_0301})
		`CHK({mq[0].wdata[7:0], mq[1].wdata[7:0]}, 16'ha1b2)
		// ---------------------------------------------------------
		// Trace ranges
		// ---------------------------------------------------------
		tool_u.send(`DPA_TC_DOWNLOAD_REQ, `DPA_OP_RANGE2, 7'd24,
			{56'h0, 24'h00_0202});
		tool_u.recv(0, m);
		`CHK(m.tcode, `DPA_TC_READY)
		upload(`DPA_OP_RANGE2);
		`CHK(m.payload[47:0], {24'h00_0202, 24'h0})
		// Ranges are set before any load or store is offered
		prog(`DPA_OP_RANGE2, 48'h0);
		prog(`DPA_OP_RANGE1, rg(25'h2000, 25'h3ff0, 2'b11));
		ls(25'h1ffc, 1'b0, 1'b0, 1'b0);
		ls(25'h2000, 1'b0, 1'b1, 1'b0);
		ls(25'h3ff0, 1'b1, 1'b0, 1'b1);
		ls(25'h3ff4, 1'b1, 1'b0, 1'b0);
		prog(`DPA_OP_RANGE1, rg(25'h2000, 25'h3ff0, 2'b01));
		ls(25'h2400, 1'b1, 1'b0, 1'b0);
		ls(25'h2400, 1'b0, 1'b1, 1'b0);
		prog(`DPA_OP_RANGE1, rg(25'h3000, 25'h2000, 2'b11));
		ls(25'h2800, 1'b0, 1'b0, 1'b0);
		prog(`DPA_OP_RANGE2, rg(25'h0100, 25'h0100, 2'b10));
		ls(25'h0100, 1'b0, 1'b0, 1'b0);
		ls(25'h0100, 1'b1, 1'b0, 1'b1);
		ls(25'h0104, 1'b1, 1'b0, 1'b0);
		prog(`DPA_OP_RANGE2, rg(25'h0100, 25'h0100, 2'b00));
		ls(25'h0100, 1'b1, 1'b0, 1'b0);
		conclude();
	end
endmodule // test_debug_port_access_and_data_trace_filter

`default_nettype wire
